// file: ccae_consts.vh
// Constants for the call, clear and arithmetic execution block
`ifndef CCAE_CONSTS_VH
`define CCAE_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CCAE_OFS_INSTR 8'h00
`define CCAE_OFS_STAT 8'h04
`define CCAE_OFS_ACC 8'h08
`define CCAE_OFS_PC 8'h0C
`define CCAE_OFS_TOS 8'h10
`define CCAE_OFS_CTRL 8'h14
`define CCAE_OFS_INFO 8'h18
`define CCAE_OFS_FILE_BASE 8'h80

// ----------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------
`define CCAE_ST_ZERO 2
`define CCAE_ST_PWRDN 3
`define CCAE_ST_WDEXP 4
`define CCAE_ST_PAGE_LO 5
`define CCAE_ST_PAGE_HI 6
`define CCAE_STAT_RESET 8'h18

// ----------------------------------------------------------------
// Other fields
// ----------------------------------------------------------------
`define CCAE_CTRL_PSA 0
`define CCAE_INFO_BUSY 0
`define CCAE_INFO_FETCH 1
`define CCAE_INFO_SKIP 2

// ----------------------------------------------------------------
// Instruction encodings, 12-bit word
// ----------------------------------------------------------------
`define CCAE_MASK_CALL 12'hF00
`define CCAE_CODE_CALL 12'h900
`define CCAE_MASK_WIPE 12'hFE0
`define CCAE_CODE_WIPE 12'h060
`define CCAE_CODE_KICK 12'h004
`define CCAE_MASK_FD 12'hFC0
`define CCAE_CODE_INVERT 12'h240
`define CCAE_CODE_MINUS 12'h0C0
`define CCAE_CODE_PLUS 12'h280
`define CCAE_CODE_DSKIP 12'h2C0
`define CCAE_BIT_DEST 5

// ----------------------------------------------------------------
// Arithmetic unit operations
// ----------------------------------------------------------------
`define CCAE_OP_WIPE 2'h0
`define CCAE_OP_INVERT 2'h1
`define CCAE_OP_MINUS 2'h2
`define CCAE_OP_PLUS 2'h3

`endif

// file: ccae_alu.v
// Eight-bit arithmetic unit for the execution block
`timescale 1ns/1ps
`include "ccae_consts.vh"

module ccae_alu (
    // Operation select
    input wire [1:0] op,
    // Operand from file register
    input wire [7:0] operand,
    // Result
    output reg [7:0] result,
    output wire zero
);

    // ----------------------------------------------------------------
    // Result selection
    // ----------------------------------------------------------------
    always @* begin
        case (op)
            `CCAE_OP_WIPE: result = 8'h00;
            `CCAE_OP_INVERT: result = ~operand;
            `CCAE_OP_MINUS: result = operand - 8'h01;
            `CCAE_OP_PLUS: result = operand + 8'h01;
            default: result = 8'h00;
        endcase
    end

    // [RULE13] Zero detect
    assign zero = (result == 8'h00);

endmodule // ccae_alu

// file: ccae_exec_core.v
// Execution of call, clear, complement, decrement and increment instructions
`timescale 1ns/1ps
`include "ccae_consts.vh"

// Notes on behaviour
// [RULE1] Call pushes program counter plus one onto the return stack first.
// [RULE2] Call loads its eight-bit target into program counter bits 7:0.
// [RULE3] Call takes counter bits 10:9 from status 6:5, clears bit 8.
// [RULE4] Call takes two cycles and changes no status flag.
// [RULE5] Register wipe writes zero to the addressed register and sets zero flag.
// [RULE6] Watchdog kick clears the counter, sets expired and power-down flags.
// [RULE7] Kick clears the prescaler only when it is assigned to the watchdog.
// [RULE8] Invert complements the register into accumulator or register, updates zero.
// [RULE9] Minus one decrements into accumulator or register, updates zero flag.
// [RULE10] Plus one increments into accumulator or register, updates zero flag.
// [RULE11] Count-down-skip decrements by destination bit and changes no flag.
// [RULE12] A zero count-down result discards the prefetched word, two cycles.
// [RULE13] Zero flag set on a zero result; other instructions take one cycle.
module ccae_exec_core #(
    parameter STACK_DEPTH = 2
) (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Watchdog side
    output reg wdt_clear,
    output reg psc_clear,
    // Core state
    output wire busy,
    output wire [10:0] pc
);

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [1:0] S_IDLE = 2'b00;
    localparam [1:0] S_EXEC = 2'b01;
    localparam [1:0] S_SECOND = 2'b10;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg dph_vld_ff;
    reg dph_write_ff;
    reg [7:0] dph_addr_ff;
    reg rd_wait_ff;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [11:0] fetch_ff;
    reg fetch_vld_ff;
    reg nxt_fetch_vld;
    reg [11:0] exec_ff;
    reg skip_ff;
    reg nxt_skip;
    reg [7:0] stat_ff;
    reg [7:0] nxt_stat;
    reg [7:0] acc_ff;
    reg [7:0] nxt_acc;
    reg [10:0] pc_ff;
    reg [10:0] nxt_pc;
    reg psa_ff;
    reg [7:0] file_ff [0:31];
    reg [10:0] stack_ff [0:STACK_DEPTH-1];
    reg push;
    reg file_we;
    reg [7:0] file_wdata;
    reg nxt_wdt_clear;
    reg nxt_psc_clear;
    reg [1:0] alu_op;
    reg [31:0] rd_mux;
    wire acc_req;
    wire fetch_take;
    wire instr_stall;
    wire wr_go;
    wire [4:0] fsel;
    wire dest_reg;
    wire [10:0] pc_inc;
    wire is_call;
    wire is_wipe;
    wire is_kick;
    wire is_invert;
    wire is_minus;
    wire is_plus;
    wire is_dskip;
    wire [7:0] alu_res;
    wire alu_zero;
    wire [4:0] bus_fsel;
    wire bus_file;
    integer i;
    integer k;

    // ----------------------------------------------------------------
    // Bus address phase
    // ----------------------------------------------------------------
    assign acc_req = hsel & htrans[1] & hready;
    assign fetch_take = (state_ff == S_IDLE) & fetch_vld_ff;
    assign instr_stall = dph_vld_ff & dph_write_ff & (dph_addr_ff == `CCAE_OFS_INSTR)
        & fetch_vld_ff & ~fetch_take;
    assign hreadyout = ~dph_vld_ff | (dph_write_ff ? ~instr_stall : rd_wait_ff);
    assign hresp = 1'b0;
    assign wr_go = dph_vld_ff & dph_write_ff & hreadyout;
    assign bus_file = dph_addr_ff[7];
    assign bus_fsel = dph_addr_ff[6:2];

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dph_vld_ff <= 1'b0;
            dph_write_ff <= 1'b0;
            dph_addr_ff <= 8'h00;
        end else if (hreadyout) begin
            dph_vld_ff <= acc_req;
            dph_write_ff <= hwrite;
            dph_addr_ff <= {haddr[7:2], 2'b00};
        end
    end

    // ----------------------------------------------------------------
    // Read data, one wait state
    // ----------------------------------------------------------------
    always @* begin
        rd_mux = 32'h0000_0000;
        if (bus_file) begin
            rd_mux = {24'h000000, file_ff[bus_fsel]};
        end else begin
            case (dph_addr_ff)
                `CCAE_OFS_INSTR: rd_mux = {20'h00000, fetch_ff};
                `CCAE_OFS_STAT: rd_mux = {24'h000000, stat_ff};
                `CCAE_OFS_ACC: rd_mux = {24'h000000, acc_ff};
                `CCAE_OFS_PC: rd_mux = {21'h000000, pc_ff};
                `CCAE_OFS_TOS: rd_mux = {21'h000000, stack_ff[0]};
                `CCAE_OFS_CTRL: rd_mux = {31'h00000000, psa_ff};
                `CCAE_OFS_INFO: rd_mux = {29'h00000000, skip_ff, fetch_vld_ff, busy};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_wait_ff <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            rd_wait_ff <= dph_vld_ff & ~dph_write_ff & ~rd_wait_ff;
            if (dph_vld_ff & ~dph_write_ff & ~rd_wait_ff) begin
                hrdata <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // Instruction decode
    // ----------------------------------------------------------------
    assign fsel = exec_ff[4:0];
    assign dest_reg = exec_ff[`CCAE_BIT_DEST];
    assign pc_inc = pc_ff + 11'h001;
    assign is_call = (exec_ff & `CCAE_MASK_CALL) == `CCAE_CODE_CALL;
    assign is_wipe = (exec_ff & `CCAE_MASK_WIPE) == `CCAE_CODE_WIPE;
    assign is_kick = exec_ff == `CCAE_CODE_KICK;
    assign is_invert = (exec_ff & `CCAE_MASK_FD) == `CCAE_CODE_INVERT;
    assign is_minus = (exec_ff & `CCAE_MASK_FD) == `CCAE_CODE_MINUS;
    assign is_plus = (exec_ff & `CCAE_MASK_FD) == `CCAE_CODE_PLUS;
    assign is_dskip = (exec_ff & `CCAE_MASK_FD) == `CCAE_CODE_DSKIP;
    assign busy = (state_ff != S_IDLE) | fetch_vld_ff;
    assign pc = pc_ff;

    always @* begin
        if (is_invert) begin
            alu_op = `CCAE_OP_INVERT;
        end else if (is_plus) begin
            alu_op = `CCAE_OP_PLUS;
        end else if (is_minus | is_dskip) begin
            alu_op = `CCAE_OP_MINUS;
        end else begin
            alu_op = `CCAE_OP_WIPE;
        end
    end

    ccae_alu ccae_alu_i (
        .op(alu_op),
        .operand(file_ff[fsel]),
        .result(alu_res),
        .zero(alu_zero)
    );

    // ----------------------------------------------------------------
    // Execution
    // ----------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        nxt_skip = skip_ff;
        nxt_stat = stat_ff;
        nxt_acc = acc_ff;
        nxt_pc = pc_ff;
        push = 1'b0;
        file_we = 1'b0;
        file_wdata = alu_res;
        nxt_wdt_clear = 1'b0;
        nxt_psc_clear = 1'b0;
        if (wr_go & ~bus_file & (dph_addr_ff == `CCAE_OFS_STAT)) begin
            nxt_stat = hwdata[7:0];
        end
        if (wr_go & ~bus_file & (dph_addr_ff == `CCAE_OFS_ACC)) begin
            nxt_acc = hwdata[7:0];
        end
        if (wr_go & ~bus_file & (dph_addr_ff == `CCAE_OFS_PC)) begin
            nxt_pc = hwdata[10:0];
        end
        case (state_ff)
            S_IDLE: begin
                if (fetch_vld_ff) begin
                    nxt_state = S_EXEC;
                end
            end
            S_EXEC: begin
                // [RULE13] Single cycle default
                nxt_state = S_IDLE;
                nxt_pc = pc_inc;
                if (is_call) begin
                    // [RULE1] Push return address
                    push = 1'b1;
                    // [RULE2] [RULE3] Compose target
                    nxt_pc = {stat_ff[`CCAE_ST_PAGE_HI:`CCAE_ST_PAGE_LO], 1'b0,
                        exec_ff[7:0]};
                    // [RULE4] Second cycle, flags kept
                    nxt_state = S_SECOND;
                end else if (is_wipe) begin
                    // [RULE5] Clear and set zero
                    file_we = 1'b1;
                    file_wdata = 8'h00;
                    nxt_stat[`CCAE_ST_ZERO] = 1'b1;
                end else if (is_kick) begin
                    // [RULE6] Watchdog restart
                    nxt_wdt_clear = 1'b1;
                    nxt_stat[`CCAE_ST_WDEXP] = 1'b1;
                    nxt_stat[`CCAE_ST_PWRDN] = 1'b1;
                    // [RULE7] Prescaler if assigned
                    nxt_psc_clear = psa_ff;
                end else if (is_invert | is_minus | is_plus) begin
                    // [RULE8] [RULE9] [RULE10] Store by destination
                    if (dest_reg) begin
                        file_we = 1'b1;
                    end else begin
                        nxt_acc = alu_res;
                    end
                    // [RULE13] Zero flag from result
                    nxt_stat[`CCAE_ST_ZERO] = alu_zero;
                end else if (is_dskip) begin
                    // [RULE11] Store, no flags
                    if (dest_reg) begin
                        file_we = 1'b1;
                    end else begin
                        nxt_acc = alu_res;
                    end
                    // [RULE12] Zero result skips
                    if (alu_zero) begin
                        nxt_skip = 1'b1;
                        nxt_state = S_SECOND;
                    end
                end
            end
            S_SECOND: begin
                nxt_skip = 1'b0;
                nxt_state = S_IDLE;
                if (skip_ff) begin
                    nxt_pc = pc_inc;
                end
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    // [RULE12] Discard prefetched word
    always @* begin
        nxt_fetch_vld = fetch_vld_ff;
        if (fetch_take) begin
            nxt_fetch_vld = 1'b0;
        end
        if (wr_go & ~bus_file & (dph_addr_ff == `CCAE_OFS_INSTR)) begin
            nxt_fetch_vld = 1'b1;
        end
        if ((state_ff == S_SECOND) & skip_ff) begin
            nxt_fetch_vld = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= S_IDLE;
            skip_ff <= 1'b0;
            fetch_ff <= 12'h000;
            fetch_vld_ff <= 1'b0;
            exec_ff <= 12'h000;
            stat_ff <= `CCAE_STAT_RESET;
            acc_ff <= 8'h00;
            pc_ff <= 11'h000;
            psa_ff <= 1'b0;
            wdt_clear <= 1'b0;
            psc_clear <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            skip_ff <= nxt_skip;
            fetch_vld_ff <= nxt_fetch_vld;
            stat_ff <= nxt_stat;
            acc_ff <= nxt_acc;
            pc_ff <= nxt_pc;
            wdt_clear <= nxt_wdt_clear;
            psc_clear <= nxt_psc_clear;
            if (wr_go & ~bus_file & (dph_addr_ff == `CCAE_OFS_INSTR)) begin
                fetch_ff <= hwdata[11:0];
            end
            if (fetch_take) begin
                exec_ff <= fetch_ff;
            end
            if (wr_go & ~bus_file & (dph_addr_ff == `CCAE_OFS_CTRL)) begin
                psa_ff <= hwdata[`CCAE_CTRL_PSA];
            end
        end
    end

    // ----------------------------------------------------------------
    // File registers and return stack
    // ----------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (i = 0; i < 32; i = i + 1) begin
                file_ff[i] <= 8'h00;
            end
        end else begin
            if (wr_go & bus_file) begin
                file_ff[bus_fsel] <= hwdata[7:0];
            end
            if (file_we) begin
                file_ff[fsel] <= file_wdata;
            end
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (k = 0; k < STACK_DEPTH; k = k + 1) begin
                stack_ff[k] <= 11'h000;
            end
        end else if (push) begin
            // [RULE1] Return address on top
            stack_ff[0] <= pc_inc;
            for (k = 1; k < STACK_DEPTH; k = k + 1) begin
                stack_ff[k] <= stack_ff[k-1];
            end
        end
    end

endmodule // ccae_exec_core

// file: ccae_exec_core_assertions.sv
// Concurrent checks on the ports of the execution block
`timescale 1ns/1ps
`include "ccae_consts.vh"

module ccae_exec_core_assertions #(
    parameter STACK_DEPTH = 2
) (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Bus
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    // Core side
    input wire wdt_clear,
    input wire psc_clear,
    input wire busy,
    input wire [10:0] pc
);
// ----------------------------------------------------------------
// Data phase tracking
// ----------------------------------------------------------------
reg dp_wr_ff;
reg [5:0] dp_idx_ff;
wire take = hsel && htrans[1] && hready;
wire instr_wr = dp_wr_ff && hready && (dp_idx_ff == 6'h00) && !busy;
wire [11:0] iw = hwdata[11:0];
wire is_call = instr_wr && ((iw & `CCAE_MASK_CALL) == `CCAE_CODE_CALL);
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        dp_wr_ff <= 1'b0;
        dp_idx_ff <= 6'h00;
    end else if (hready) begin
        dp_wr_ff <= take && hwrite;
        dp_idx_ff <= haddr[7:2];
    end
end
default clocking dc @(posedge clk); endclocking
default disable iff (!resetn);
// ----------------------------------------------------------------
// Assertions
// ----------------------------------------------------------------
okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not OKAY");
read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
write_ready_a: assert property (take && hwrite && haddr[7:2] != 6'h00 |=> hreadyout)
    else $error("register write stalled");
// Kick pulses watchdog
kick_pulse_a: assert property (instr_wr && iw == `CCAE_CODE_KICK |-> ##3 wdt_clear)
    else $error("kick gave no watchdog clear");
pulse_once_a: assert property (wdt_clear |=> !wdt_clear)
    else $error("watchdog clear longer than one cycle");
// Prescaler only with kick
psc_pair_a: assert property (psc_clear |-> wdt_clear)
    else $error("prescaler clear without kick");
call_target_a: assert property (is_call |-> ##3 (pc[7:0] == $past(iw[7:0], 3) && !pc[8]))
    else $error("call target wrong");
call_two_cycle_a: assert property (is_call |-> ##1 busy [*3] ##1 !busy)
    else $error("call not two cycles");
wipe_one_cycle_a: assert property (
    instr_wr && (iw & `CCAE_MASK_WIPE) == `CCAE_CODE_WIPE |-> ##1 busy [*2] ##1 !busy)
    else $error("wipe not one cycle");
invert_pc_a: assert property (
    instr_wr && (iw & `CCAE_MASK_FD) == `CCAE_CODE_INVERT |-> ##3 pc == $past(pc, 3) + 11'h001)
    else $error("pc not advanced by one");
endmodule // ccae_exec_core_assertions

// file: ccae_exec_core_test.sv
// Self-checking testbench for the execution block
`timescale 1ns/1ps
`include "ccae_consts.vh"
`define CHK(nm, ex, got) begin \
    checks_done = checks_done + 1; \
    if ((got) !== (ex)) begin \
        mismatches = mismatches + 1; \
        $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
    end \
end

module ccae_exec_core_test;
reg clk, resetn, hsel, hwrite, rdy_s, busy_s;
reg [1:0] htrans;
reg [2:0] hsize;
reg [31:0] haddr, hwdata, rdata_s, rv, r1, r2;
reg [10:0] m_pc;
wire hreadyout, hresp, wdt_clear, psc_clear, busy;
wire [31:0] hrdata;
wire [10:0] pc;
integer mismatches, checks_done, wdt_cnt, psc_cnt, i, j;
reg [7:0] corner [0:2];

ccae_exec_core #(.STACK_DEPTH(2)) ccae_exec_core_i (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .wdt_clear(wdt_clear), .psc_clear(psc_clear), .busy(busy), .pc(pc));

initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
end
// ----------------------------------------------------------------
// Mid-cycle sampling of outputs
// ----------------------------------------------------------------
always @(negedge clk) begin
    rdy_s = hreadyout;
    busy_s = busy;
    rdata_s = hrdata;
    if (wdt_clear === 1'b1) wdt_cnt = wdt_cnt + 1;
    if (psc_clear === 1'b1) psc_cnt = psc_cnt + 1;
end

task results;
    begin
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    end
endtask

task bus_wait;
    integer n;
    begin
        n = 0;
        @(posedge clk);
        while (rdy_s !== 1'b1 && n < 50) begin
            n = n + 1;
            @(posedge clk);
        end
        if (n >= 50) mismatches = mismatches + 1;
    end
endtask

task wr(input [31:0] a, input [31:0] d);
    begin
        haddr <= a;
        hwrite <= 1'b1;
        htrans <= 2'h2;
        bus_wait;
        htrans <= 2'h0;
        hwdata <= d;
        bus_wait;
    end
endtask

task rd(input [31:0] a);
    begin
        haddr <= a;
        hwrite <= 1'b0;
        htrans <= 2'h2;
        bus_wait;
        htrans <= 2'h0;
        bus_wait;
        rv = rdata_s;
    end
endtask

task settle;
    integer n;
    begin
        n = 0;
        @(posedge clk);
        while (busy_s !== 1'b0 && n < 20) begin
            n = n + 1;
            @(posedge clk);
        end
        if (n >= 20) mismatches = mismatches + 1;
    end
endtask

function [31:0] fa(input [4:0] f);
    fa = {24'h0, `CCAE_OFS_FILE_BASE} + {25'h0, f, 2'h0};
endfunction

function [7:0] exp_res(input [2:0] kind, input [7:0] v);
    case (kind)
        3'd0: exp_res = 8'h00;
        3'd1: exp_res = ~v;
        3'd2, 3'd4: exp_res = v - 8'h01;
        3'd3: exp_res = v + 8'h01;
        default: exp_res = v;
    endcase
endfunction

task run_op(input [2:0] kind, input [4:0] f, input d, input [7:0] v, input [7:0] a,
            input [7:0] s_in, input [7:0] k, input psa);
    reg [11:0] w;
    reg [7:0] res, e_acc, e_file, e_st, st;
    reg [10:0] e_pc;
    integer w0, p0;
    begin
        st = (kind == 3'd5) ? (s_in & 8'h64) : ((s_in & 8'h64) | 8'h18);
        case (kind)
            3'd0: w = `CCAE_CODE_WIPE | {7'h0, f};
            3'd1: w = `CCAE_CODE_INVERT | {6'h0, d, f};
            3'd2: w = `CCAE_CODE_MINUS | {6'h0, d, f};
            3'd3: w = `CCAE_CODE_PLUS | {6'h0, d, f};
            3'd4: w = `CCAE_CODE_DSKIP | {6'h0, d, f};
            3'd5: w = `CCAE_CODE_KICK;
            3'd6: w = `CCAE_CODE_CALL | {4'h0, k};
            default: w = 12'h000;
        endcase
        res = exp_res(kind, v);
        e_acc = a;
        e_file = (kind == 3'd0) ? 8'h00 : v;
        if (kind >= 3'd1 && kind <= 3'd4) begin
            if (d) e_file = res;
            else e_acc = res;
        end
        e_st = st;
        if (kind <= 3'd3) e_st[`CCAE_ST_ZERO] = (res == 8'h00);
        if (kind == 3'd5) e_st = st | 8'h18;
        e_pc = m_pc + ((kind == 3'd4 && res == 8'h00) ? 11'h002 : 11'h001);
        if (kind == 3'd6) e_pc = {st[6:5], 1'b0, k};
        wr({24'h0, `CCAE_OFS_CTRL}, {31'h0, psa});
        wr({24'h0, `CCAE_OFS_STAT}, {24'h0, st});
        wr({24'h0, `CCAE_OFS_ACC}, {24'h0, a});
        wr(fa(f), {24'h0, v});
        w0 = wdt_cnt;
        p0 = psc_cnt;
        wr({24'h0, `CCAE_OFS_INSTR}, {20'h0, w});
        settle;
        rd({24'h0, `CCAE_OFS_ACC});
        `CHK("accumulator", e_acc, rv[7:0])
        rd(fa(f));
        `CHK("file register", e_file, rv[7:0])
        rd({24'h0, `CCAE_OFS_STAT});
        `CHK("status", e_st, rv[7:0])
        `CHK("pc", e_pc, pc)
        if (kind == 3'd6) begin
            rd({24'h0, `CCAE_OFS_TOS});
            `CHK("stack top", m_pc + 11'h001, rv[10:0])
        end
        `CHK("watchdog clears", w0 + (kind == 3'd5), wdt_cnt)
        `CHK("prescaler clears", p0 + (kind == 3'd5 && psa), psc_cnt)
        m_pc = e_pc;
    end
endtask

task skip_pair(input [7:0] v);
    begin
        wr(fa(5'd3), {24'h0, v});
        wr(fa(5'd4), 32'h10);
        wr({24'h0, `CCAE_OFS_INSTR}, {20'h0, `CCAE_CODE_DSKIP | 12'h023});
        wr({24'h0, `CCAE_OFS_INSTR}, {20'h0, `CCAE_CODE_PLUS | 12'h024});
        settle;
        rd(fa(5'd4));
        `CHK("word after skip", (v == 8'h01) ? 8'h10 : 8'h11, rv[7:0])
        rd(fa(5'd3));
        `CHK("count down", v - 8'h01, rv[7:0])
        `CHK("pc after pair", m_pc + 11'h002, pc)
        m_pc = m_pc + 11'h002;
    end
endtask

initial begin
    #(50 * 20000);
    mismatches = mismatches + 1;
    results;
end

initial begin
    resetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mismatches = 0;
    checks_done = 0;
    wdt_cnt = 0;
    psc_cnt = 0;
    m_pc = 11'h000;
    corner[0] = 8'h01;
    corner[1] = 8'hFF;
    corner[2] = 8'h00;
    r1 = $urandom(32'h4930);
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd({24'h0, `CCAE_OFS_STAT});
    `CHK("status reset", `CCAE_STAT_RESET, rv[7:0])
    rd({24'h0, `CCAE_OFS_ACC});
    `CHK("acc reset", 32'h0, rv)
    `CHK("pc reset", 11'h000, pc)
    wr(32'h40, 32'hFFFFFFFF);
    rd(32'h40);
    `CHK("unmapped", 32'h0, rv)
    wr({24'h0, `CCAE_OFS_TOS}, 32'h7FF);
    rd({24'h0, `CCAE_OFS_TOS});
    `CHK("stack read only", 32'h0, rv)
    wr({24'h0, `CCAE_OFS_CTRL}, 32'h1);
    rd({24'h0, `CCAE_OFS_CTRL});
    `CHK("ctrl readback", 32'h1, rv)
    r1 = $urandom;
    wr({24'h0, `CCAE_OFS_PC}, r1);
    m_pc = r1[10:0];
    rd({24'h0, `CCAE_OFS_PC});
    `CHK("pc readback", m_pc, rv[10:0])
    `CHK("pc port", m_pc, pc)
    rd({24'h0, `CCAE_OFS_INFO});
    `CHK("info idle", 32'h0, rv)
    for (j = 0; j < 3; j = j + 1) begin
        for (i = 0; i < 8; i = i + 1) begin
            r1 = $urandom;
            run_op(i[2:0], r1[4:0], r1[5], corner[j], r1[15:8], r1[23:16], r1[31:24], j[0]);
        end
    end
    repeat (60) begin
        r1 = $urandom;
        r2 = $urandom;
        run_op(r1[2:0], r1[7:3], r1[8], r2[7:0], r2[15:8], r2[23:16], r1[23:16], r1[9]);
    end
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    m_pc = 11'h000;
    `CHK("pc after reset", 11'h000, pc)
    rd({24'h0, `CCAE_OFS_STAT});
    `CHK("status after reset", `CCAE_STAT_RESET, rv[7:0])
    skip_pair(8'h01);
    skip_pair(8'h05);
    skip_pair(8'h00);
    results;
end
endmodule // ccae_exec_core_test

bind ccae_exec_core ccae_exec_core_assertions #(.STACK_DEPTH(STACK_DEPTH))
    ccae_exec_core_assertions_i (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wdt_clear(wdt_clear),
    .psc_clear(psc_clear), .busy(busy), .pc(pc));
